//--- flash_consts.svh
// Constants for the flash write guard and power controller
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// ==========================================================
// Control byte layout
`define CTL_MAN_BIT      0
`define CTL_AUTO_BIT     1
`define CTL_ABORT_BIT    3
`define CTL_KEY_LSB      4
`define CTL_KEY_MSB      7
`define KEY_ENABLE       4'h3
`define KEY_PROTECT      4'hc
`define MAN_RESET        1'b1
`define AUTO_RESET       1'b0

// ==========================================================
// Status byte layout
`define STAT_WIP_BIT     0
`define STAT_READY_BIT   1

// ==========================================================
// Flash window, page and fill byte
`define FLASH_BASE       16'h4000
`define FILL_BYTE        8'hff
`define PAGE_BYTES       128

// ==========================================================
// Warm-up lengths in periods of the selected clock
`define WARM_FC_PERIODS  1024
`define WARM_FS_PERIODS  8
`define FC_DIV_DEFAULT   1
`define FS_DIV_DEFAULT   3815

// ==========================================================
// Host Wishbone register offsets
`define HOST_CTRL        8'h00
`define HOST_STATUS      8'h04
`define HOST_ADDR        8'h08
`define HOST_DATA        8'h0c
`define HOST_MODE        8'h10
`define HOST_EVENT       8'h14
`define MODE_RAM_BIT     0
`define MODE_PROM_BIT    1
`define MODE_SLOW_BIT    2
`define MODE_FETCH_BIT   3
`define EV_STOP_IN       0
`define EV_STOP_OUT      1
`define EV_HALT_IN       2
`define EV_HALT_OUT      3
`define EV_NMI           4

`endif

//--- flash_cpu_end.sv
// CPU-side end: Wishbone slave that drives the flash control link
`include "flash_consts.svh"
`timescale 1ns/100ps
module flash_cpu_end
  import flash_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             cpu_halted_o,
  output logic             soft_int_o,
  flash_link_if.cpu        link
);

  logic [1:0]  pend_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] addr_reg;
  logic [3:0]  mode_reg;
  logic        ctrl_we_reg;
  logic        fl_we_reg;
  logic        fl_re_reg;
  logic [7:0]  wdata_reg;
  logic [4:0]  ev_reg;

  // ==========================================================
  // Decoding
  // A halted CPU takes no new request until the wait is over
  wire req      = wb_cyc_i && wb_stb_i && !ack_reg && (pend_reg == 2'd0)
               && !link.cpu_wait;
  wire lane0    = wb_sel_i[0];
  wire wr       = req && wb_we_i && lane0;
  wire hit_ctrl = (wb_adr_i == `HOST_CTRL);
  wire hit_addr = (wb_adr_i == `HOST_ADDR);
  wire hit_data = (wb_adr_i == `HOST_DATA);
  wire hit_mode = (wb_adr_i == `HOST_MODE);
  wire hit_ev   = (wb_adr_i == `HOST_EVENT);
  wire [31:0] rd_mux =
      hit_ctrl ? {24'h000000, link.ctrl_rdata} :
      (wb_adr_i == `HOST_STATUS) ? {24'h000000, link.stat_rdata} :
      hit_addr ? {16'h0000, addr_reg} :
      hit_data ? {24'h000000, link.fl_rdata} :
      hit_mode ? {28'h0000000, mode_reg} : 32'h00000000;

  // ==========================================================
  // Bus sequencing: request, two settle cycles, then ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 2'd0;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h00000000;
    end else begin
      ack_reg <= (pend_reg == 2'd2);
      if (req) begin
        pend_reg <= 2'd1;
      end else if (pend_reg != 2'd0) begin
        // Spacing keeps strobes at least two cycles apart
        pend_reg <= (pend_reg == 2'd2) ? 2'd0 : 2'd2;
      end
      if (pend_reg == 2'd2) begin
        dat_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Link strobes and held values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg    <= 16'h0000;
      mode_reg    <= 4'h0;
      ctrl_we_reg <= 1'b0;
      fl_we_reg   <= 1'b0;
      fl_re_reg   <= 1'b0;
      wdata_reg   <= 8'h00;
      ev_reg      <= 5'h00;
    end else begin
      ctrl_we_reg <= wr && hit_ctrl;
      fl_we_reg   <= wr && hit_data;
      fl_re_reg   <= req && !wb_we_i && hit_data;
      ev_reg      <= (wr && hit_ev) ? wb_dat_i[4:0] : 5'h00;
      if (wr) begin
        wdata_reg <= wb_dat_i[7:0];
      end
      if (wr && hit_addr && wb_sel_i[1]) begin
        addr_reg <= wb_dat_i[15:0];
      end
      if (wr && hit_mode) begin
        mode_reg <= wb_dat_i[3:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = dat_reg;
  assign cpu_halted_o    = link.cpu_wait;
  assign soft_int_o      = link.soft_int;
  assign link.ctrl_we    = ctrl_we_reg;
  assign link.ctrl_wdata = wdata_reg;
  assign link.fl_we      = fl_we_reg;
  assign link.fl_re      = fl_re_reg;
  assign link.fl_wdata   = wdata_reg;
  assign link.fl_addr    = addr_reg;
  assign link.exec_ram   = mode_reg[`MODE_RAM_BIT];
  assign link.prom_mode  = mode_reg[`MODE_PROM_BIT];
  assign link.slow_sel   = mode_reg[`MODE_SLOW_BIT];
  assign link.fl_fetch   = mode_reg[`MODE_FETCH_BIT];
  assign link.stop_enter = ev_reg[`EV_STOP_IN];
  assign link.stop_exit  = ev_reg[`EV_STOP_OUT];
  assign link.halt_enter = ev_reg[`EV_HALT_IN];
  assign link.halt_exit  = ev_reg[`EV_HALT_OUT];
  assign link.nmi        = ev_reg[`EV_NMI];

endmodule

//--- flash_guard.sv
// Flash write guard, forced stop and power gating controller
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`include "flash_consts.svh"
`timescale 1ns/100ps
module flash_guard
  import flash_pkg::*;
#(
  parameter int FC_DIV = `FC_DIV_DEFAULT,
  parameter int FS_DIV = `FS_DIV_DEFAULT
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  flash_link_if.dev       link,
  output logic            buf_wr_o,
  output logic [6:0]      buf_idx_o,
  output logic [7:0]      buf_data_o,
  output logic [9:0]      page_o,
  output logic            prog_start_o,
  input  wire logic       prog_done_i,
  input  wire logic [7:0] array_rdata_i,
  output logic            power_on_o
);

  localparam logic [10:0] FC_LAST = 11'(`WARM_FC_PERIODS - 1);
  localparam logic [10:0] FS_LAST = 11'(`WARM_FS_PERIODS - 1);
  localparam logic [6:0]  IDX_LAST = 7'(`PAGE_BYTES - 1);

  generate
    if (FC_DIV < 1 || FS_DIV < 1 || FC_DIV > 65535 || FS_DIV > 65535) begin
      $error("flash_guard: divider out of range");
    end
  endgenerate

  // ==========================================================
  // Clock enables for the fast and slow warm-up rates
  logic [15:0]  fc_div_reg;
  logic [15:0]  fs_div_reg;
  wire          fc_tick = (fc_div_reg == 16'(FC_DIV - 1));
  wire          fs_tick = (fs_div_reg == 16'(FS_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || fc_tick) begin
      fc_div_reg <= 16'h0000;
    end else begin
      fc_div_reg <= fc_div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || fs_tick) begin
      fs_div_reg <= 16'h0000;
    end else begin
      fs_div_reg <= fs_div_reg + 16'h0001;
    end
  end

  // ==========================================================
  // State
  power_state_t state_reg;
  power_state_t state_next;
  logic [3:0]   key_reg;
  logic         man_reg;
  logic         auto_reg;
  logic         wip_reg;
  logic         prog_reg;
  logic [6:0]   cnt_reg;
  logic [10:0]  wcnt_reg;
  logic         wait_reg;
  logic         wait_next;
  logic [7:0]   rdata_reg;
  logic         sint_reg;
  logic [9:0]   page_reg;

  // ==========================================================
  // Decoding
  wire        ready     = (state_reg == ST_ON);
  wire        ctrl_ok   = link.ctrl_we && link.exec_ram;
  wire        man_wr    = link.ctrl_wdata[`CTL_MAN_BIT];
  wire        man_rise  = ctrl_ok && man_wr && !man_reg;
  wire        man_fall  = ctrl_ok && !man_wr && man_reg;
  wire        abort_req = ctrl_ok && link.ctrl_wdata[`CTL_ABORT_BIT];
  wire        nmi_wake  = link.nmi && !man_reg;
  wire        halt_cut  = man_reg && !auto_reg;
  // Stop always cuts a powered circuit; halt only with auto clear
  wire        power_cut = man_fall
                       || (link.stop_enter && man_reg)
                       || (link.halt_enter && halt_cut);
  // Release from stop or halt only warms if the circuit was powered
  wire        wake_wait = nmi_wake
                       || (link.stop_exit && man_reg)
                       || (link.halt_exit && halt_cut);
  wire        abort_warm = abort_req && wip_reg;
  wire        tick      = link.slow_sel ? fs_tick : fc_tick;
  wire [10:0] warm_last = link.slow_sel ? FS_LAST : FC_LAST;
  wire        warm_done = tick && (wcnt_reg == warm_last);
  wire        in_range  = (link.fl_addr >= `FLASH_BASE);
  // Writes during a pending program or an abort are dropped silently
  wire        write_ok  = link.fl_we && (key_reg == `KEY_ENABLE)
                       && link.prom_mode && in_range
                       && ready && !prog_reg && !abort_req;
  wire        page_full = write_ok && (cnt_reg == IDX_LAST);
  wire        wip_done  = (state_reg == ST_ABORT && warm_done)
                       || prog_done_i;

  // ==========================================================
  // Power and warm-up sequencer
  always_comb begin
    state_next = state_reg;
    wait_next  = 1'b0;
    case (state_reg)
      ST_OFF: begin
        if (wake_wait || man_rise) begin
          state_next = ST_WARM;
          wait_next  = wake_wait;
        end
      end
      ST_WARM: begin
        if (power_cut) begin
          state_next = ST_OFF;
        end else if (warm_done) begin
          state_next = ST_ON;
        end else begin
          // NMI during a polled warm-up still halts the CPU
          wait_next = wait_reg || link.nmi;
        end
      end
      ST_ON: begin
        if (power_cut) begin
          state_next = ST_OFF;
        end else if (abort_warm) begin
          state_next = ST_ABORT;
          wait_next  = 1'b1;
        end
      end
      ST_ABORT: begin
        if (power_cut) begin
          state_next = ST_OFF;
        end else if (warm_done) begin
          state_next = ST_ON;
        end else begin
          wait_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_WARM;
      wait_reg  <= 1'b0;
      wcnt_reg  <= 11'h000;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      if (state_next != state_reg) begin
        wcnt_reg <= 11'h000;
      end else if (tick) begin
        wcnt_reg <= wcnt_reg + 11'h001;
      end
    end
  end

  // ==========================================================
  // Control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_reg  <= `KEY_PROTECT;
      man_reg  <= `MAN_RESET;
      auto_reg <= `AUTO_RESET;
    end else begin
      if (ctrl_ok) begin
        key_reg <= link.ctrl_wdata[`CTL_KEY_MSB:`CTL_KEY_LSB];
      end
      if (nmi_wake) begin
        man_reg <= 1'b1;
      end else if (ctrl_ok) begin
        man_reg <= man_wr;
      end
      // Auto bit is writable from any fetch area
      if (link.ctrl_we) begin
        auto_reg <= link.ctrl_wdata[`CTL_AUTO_BIT];
      end
    end
  end

  // ==========================================================
  // Page buffer counter and busy flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 7'h00;
      wip_reg  <= 1'b0;
      prog_reg <= 1'b0;
      page_reg <= 10'h000;
    end else begin
      if (abort_req) begin
        cnt_reg <= 7'h00;
      end else if (write_ok) begin
        cnt_reg <= cnt_reg + 7'h01;
      end
      if (write_ok && cnt_reg == 7'h00) begin
        wip_reg  <= 1'b1;
        page_reg <= link.fl_addr[15:6];
      end else if (wip_done) begin
        wip_reg <= 1'b0;
      end
      // Program only starts on a full page; an abort before it
      // leaves the array untouched
      if (page_full) begin
        prog_reg <= 1'b1;
      end else if (wip_done) begin
        prog_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_wr_o     <= 1'b0;
      buf_idx_o    <= 7'h00;
      buf_data_o   <= 8'h00;
      prog_start_o <= 1'b0;
    end else begin
      buf_wr_o     <= write_ok;
      buf_idx_o    <= cnt_reg;
      buf_data_o   <= link.fl_wdata;
      prog_start_o <= page_full;
    end
  end

  // ==========================================================
  // Flash read path
  wire        can_read  = ready && !wip_reg;
  wire [7:0]  read_byte = can_read ? array_rdata_i : `FILL_BYTE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= `FILL_BYTE;
      sint_reg  <= 1'b0;
    end else begin
      if (link.fl_re) begin
        rdata_reg <= read_byte;
      end
      sint_reg <= link.fl_re && link.fl_fetch && (read_byte == `FILL_BYTE);
    end
  end

  // ==========================================================
  // Outputs
  assign page_o          = page_reg;
  assign power_on_o      = (state_reg != ST_OFF);
  assign link.cpu_wait   = wait_reg;
  assign link.soft_int   = sint_reg;
  assign link.fl_rdata   = rdata_reg;
  assign link.ctrl_rdata = {key_reg, 2'b00, auto_reg, man_reg};
  assign link.stat_rdata = {6'h00, ready, wip_reg};

endmodule

//--- flash_link_assertions.sv
// Checker for the link between the CPU end and the flash controller
`timescale 1ns/100ps
module flash_link_assertions #(
  parameter int FC_DIV = 1,
  parameter int FS_DIV = 2
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ctrl_we,
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       exec_ram,
  input  wire logic       slow_sel,
  input  wire logic       fl_re,
  input  wire logic       fl_fetch,
  input  wire logic       stop_exit,
  input  wire logic       halt_enter,
  input  wire logic       nmi,
  input  wire logic [7:0] ctrl_rdata,
  input  wire logic [7:0] stat_rdata,
  input  wire logic [7:0] fl_rdata,
  input  wire logic       cpu_wait,
  input  wire logic       soft_int
);
  // ====
  // Setup
  // First tick phase is unknown, so warm-up length gets a small margin
  localparam int FL = 1024 * FC_DIV - 4;
  localparam int FH = 1024 * FC_DIV + 2;
  localparam int SL = 7 * FS_DIV - 2;
  localparam int SH = 8 * FS_DIV + 2;
  logic [15:0] wait_len_reg;
  wire         ram_wr = ctrl_we && exec_ram && !nmi;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || !cpu_wait) wait_len_reg <= 16'h0000;
    else wait_len_reg <= wait_len_reg + 16'h0001;
  end

  // ====
  // Properties
  key_guard_a: assert property (ctrl_we && !exec_ram && !nmi |=>
    $stable({ctrl_rdata[7:4], ctrl_rdata[0]})) else $error("key changed");
  key_load_a: assert property (ram_wr |=>
    ctrl_rdata[7:4] == $past(ctrl_wdata[7:4])) else $error("key lost");
  auto_load_a: assert property (ctrl_we |=>
    ctrl_rdata[1] == $past(ctrl_wdata[1])) else $error("auto lost");
  power_cut_a: assert property (ram_wr && !ctrl_wdata[0] |=>
    !stat_rdata[1]) else $error("power not cut");
  polled_warm_a: assert property (ram_wr && ctrl_wdata[0] && !ctrl_rdata[0]
    |=> (!cpu_wait && !stat_rdata[1]) [*8]) else $error("bad polled warm");
  abort_idle_a: assert property (ram_wr && ctrl_wdata[3] && !stat_rdata[0]
    |=> !cpu_wait) else $error("idle abort waited");
  abort_busy_a: assert property (ram_wr && ctrl_wdata[3] && ctrl_wdata[0]
    && stat_rdata[1:0] == 2'b11 |=> cpu_wait) else $error("abort no wait");
  wait_fast_a: assert property ($fell(cpu_wait) && !slow_sel |->
    wait_len_reg inside {[FL:FH]}) else $error("fast wait length");
  wait_slow_a: assert property ($fell(cpu_wait) && slow_sel |->
    wait_len_reg inside {[SL:SH]}) else $error("slow wait length");
  blank_read_a: assert property (fl_re && !stat_rdata[1] |=>
    fl_rdata == 8'hff && soft_int == $past(fl_fetch)) else $error("blank");
  nmi_wake_a: assert property (nmi && !ctrl_rdata[0] |=>
    ctrl_rdata[0] && cpu_wait) else $error("nmi no wake");
  stop_wake_a: assert property (stop_exit && ctrl_rdata[0] |=>
    cpu_wait) else $error("stop exit no wait");
  stay_off_a: assert property (stop_exit && !ctrl_rdata[0] && !nmi |=>
    !cpu_wait && !stat_rdata[1]) else $error("woke while off");
  halt_cut_a: assert property (halt_enter && ctrl_rdata[1:0] == 2'b01 |=>
    !stat_rdata[1]) else $error("halt kept power");
  halt_keep_a: assert property (halt_enter && ctrl_rdata[1:0] == 2'b11
    && stat_rdata[1] |=> stat_rdata[1]) else $error("halt cut power");

  cover property (ram_wr && ctrl_wdata[3] && stat_rdata[0]);
  cover property (nmi && !ctrl_rdata[0]);
  cover property (halt_enter && ctrl_rdata[1:0] == 2'b11);
endmodule

//--- flash_link_if.sv
// Link between the CPU side and the flash controller
`timescale 1ns/100ps
interface flash_link_if;
  logic        ctrl_we;
  logic [7:0]  ctrl_wdata;
  logic        exec_ram;
  logic        prom_mode;
  logic        slow_sel;
  logic        fl_we;
  logic        fl_re;
  logic        fl_fetch;
  logic [15:0] fl_addr;
  logic [7:0]  fl_wdata;
  logic        stop_enter;
  logic        stop_exit;
  logic        halt_enter;
  logic        halt_exit;
  logic        nmi;
  logic [7:0]  ctrl_rdata;
  logic [7:0]  stat_rdata;
  logic [7:0]  fl_rdata;
  logic        cpu_wait;
  logic        soft_int;

  modport dev (
    input  ctrl_we, ctrl_wdata, exec_ram, prom_mode, slow_sel,
    input  fl_we, fl_re, fl_fetch, fl_addr, fl_wdata,
    input  stop_enter, stop_exit, halt_enter, halt_exit, nmi,
    output ctrl_rdata, stat_rdata, fl_rdata, cpu_wait, soft_int
  );

  modport cpu (
    output ctrl_we, ctrl_wdata, exec_ram, prom_mode, slow_sel,
    output fl_we, fl_re, fl_fetch, fl_addr, fl_wdata,
    output stop_enter, stop_exit, halt_enter, halt_exit, nmi,
    input  ctrl_rdata, stat_rdata, fl_rdata, cpu_wait, soft_int
  );
endinterface

//--- flash_pkg.sv
// Types shared by both ends of the flash control link
package flash_pkg;

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_WARM  = 4'b0010,
    ST_ON    = 4'b0100,
    ST_ABORT = 4'b1000
  } power_state_t;

endpackage

//--- tb_flash_write_guard_power_ctrl.sv
// Testbench joining both ends of the flash write guard and power control
`include "flash_consts.svh"
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_flash_write_guard_power_ctrl;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        prog_done_i = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  array_rdata_i = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] lfsr = 32'hec437d67;
  logic [31:0] rd_q[$];
  logic [15:0] bw_q[$];
  wire  [31:0] rdat;
  wire  [9:0]  page;
  wire  [7:0]  bdata;
  wire  [6:0]  idx;
  wire         ack, halted, sint, buf_wr, prog_start, pwr;
  int          error_cnt = 0, num_checks = 0, prog_cnt = 0, sint_cnt = 0;

  always #4 clk_i = ~clk_i;

  flash_link_if flash_link_if_i ();
  flash_guard #(.FC_DIV(1), .FS_DIV(2)) flash_guard_i (.clk_i(clk_i),
    .rst_i(rst_i), .link(flash_link_if_i.dev), .buf_wr_o(buf_wr),
    .buf_idx_o(idx), .buf_data_o(bdata), .page_o(page),
    .prog_start_o(prog_start), .prog_done_i(prog_done_i),
    .array_rdata_i(array_rdata_i), .power_on_o(pwr));
  flash_cpu_end flash_cpu_end_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_halted_o(halted), .soft_int_o(sint), .link(flash_link_if_i.cpu));
  flash_link_assertions #(.FC_DIV(1), .FS_DIV(2)) flash_link_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .ctrl_we(flash_link_if_i.ctrl_we),
    .ctrl_wdata(flash_link_if_i.ctrl_wdata),
    .exec_ram(flash_link_if_i.exec_ram), .slow_sel(flash_link_if_i.slow_sel),
    .fl_re(flash_link_if_i.fl_re), .fl_fetch(flash_link_if_i.fl_fetch),
    .stop_exit(flash_link_if_i.stop_exit),
    .halt_enter(flash_link_if_i.halt_enter), .nmi(flash_link_if_i.nmi),
    .ctrl_rdata(flash_link_if_i.ctrl_rdata),
    .stat_rdata(flash_link_if_i.stat_rdata),
    .fl_rdata(flash_link_if_i.fl_rdata), .cpu_wait(flash_link_if_i.cpu_wait),
    .soft_int(flash_link_if_i.soft_int));

  // ====
  // Helpers
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Waits through cpu_wait too, since the CPU end holds off taking then
  // Only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic fill(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      bw_q.push_back({1'b0, 7'(i), lfsr[7:0]});
      wb(1'b1, `HOST_DATA, {24'h0, lfsr[7:0]});
    end
  endtask

  task automatic wait_ready;
    for (int n = 0; n < 5000 && flash_link_if_i.stat_rdata[1] !== 1'b1; n++)
      @(posedge clk_i);
  endtask

  // ====
  // Watchers
  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we) `CHK(rdat, rd_q.pop_front())
    if (buf_wr === 1'b1) `CHK({1'b0, idx, bdata},
      bw_q.size() > 0 ? bw_q.pop_front() : 16'hffff)
    if (prog_start === 1'b1) prog_cnt++;
    if (prog_start === 1'b1) `CHK(page, 10'h102)
    if (sint === 1'b1) sint_cnt++;
  end

  initial begin
    #(8 * 30000);
    error_cnt++;
    end_of_test();
  end

  // ====
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`HOST_CTRL, 32'hc1);
    rd(`HOST_STATUS, 32'h0);
    wait_ready();
    rd(`HOST_STATUS, 32'h2);
    $display("reset test done");
    wb(1'b1, `HOST_MODE, 32'h2);
    wb(1'b1, `HOST_CTRL, 32'h31);
    rd(`HOST_CTRL, 32'hc1);
    wb(1'b1, `HOST_ADDR, 32'h4080);
    wb(1'b1, `HOST_DATA, 32'h5a);
    wb(1'b1, `HOST_MODE, 32'h3);
    wb(1'b1, `HOST_CTRL, 32'h31);
    rd(`HOST_CTRL, 32'h31);
    wb(1'b1, `HOST_MODE, 32'h1);
    wb(1'b1, `HOST_DATA, 32'h5a);
    wb(1'b1, `HOST_MODE, 32'h3);
    wb(1'b1, `HOST_ADDR, 32'h3fff);
    wb(1'b1, `HOST_DATA, 32'h5a);
    rd(`HOST_STATUS, 32'h2);
    $display("guard test done");
    wb(1'b1, `HOST_ADDR, 32'h4080);
    fill(5);
    rd(`HOST_STATUS, 32'h3);
    wb(1'b1, `HOST_CTRL, 32'h39);
    @(negedge clk_i);
    `CHK(halted, 1'b1)
    rd(`HOST_STATUS, 32'h2);
    `CHK(prog_cnt, 0)
    wb(1'b1, `HOST_CTRL, 32'h39);
    @(negedge clk_i);
    `CHK(halted, 1'b0)
    fill(128);
    repeat (3) @(posedge clk_i);
    `CHK(prog_cnt, 1)
    rd(`HOST_STATUS, 32'h3);
    prog_done_i <= 1'b1;
    @(posedge clk_i);
    prog_done_i <= 1'b0;
    rd(`HOST_STATUS, 32'h2);
    $display("abort test done");
    wb(1'b1, `HOST_CTRL, 32'hc0);
    @(negedge clk_i);
    `CHK(pwr, 1'b0)
    wb(1'b1, `HOST_MODE, 32'h9);
    rd(`HOST_DATA, 32'hff);
    @(negedge clk_i);
    `CHK(sint_cnt, 1)
    wb(1'b1, `HOST_EVENT, 32'h1);
    wb(1'b1, `HOST_EVENT, 32'h2);
    rd(`HOST_STATUS, 32'h0);
    wb(1'b1, `HOST_EVENT, 32'h10);
    rd(`HOST_CTRL, 32'hc1);
    rd(`HOST_STATUS, 32'h2);
    array_rdata_i <= lfsr[15:8];
    wb(1'b1, `HOST_MODE, 32'h1);
    rd(`HOST_DATA, {24'h0, lfsr[15:8]});
    wb(1'b1, `HOST_MODE, 32'h5);
    wb(1'b1, `HOST_CTRL, 32'hc0);
    wb(1'b1, `HOST_CTRL, 32'hc1);
    @(negedge clk_i);
    `CHK(halted, 1'b0)
    wait_ready();
    wb(1'b1, `HOST_EVENT, 32'h1);
    wb(1'b1, `HOST_EVENT, 32'h2);
    rd(`HOST_STATUS, 32'h2);
    $display("power test done");
    wb(1'b1, `HOST_MODE, 32'h1);
    wb(1'b1, `HOST_EVENT, 32'h4);
    rd(`HOST_STATUS, 32'h0);
    wb(1'b1, `HOST_EVENT, 32'h8);
    @(negedge clk_i);
    `CHK(halted, 1'b1)
    rd(`HOST_STATUS, 32'h2);
    wb(1'b1, `HOST_MODE, 32'h0);
    wb(1'b1, `HOST_CTRL, 32'h03);
    rd(`HOST_CTRL, 32'hc3);
    wb(1'b1, `HOST_EVENT, 32'h4);
    rd(`HOST_STATUS, 32'h2);
    wb(1'b1, `HOST_EVENT, 32'h8);
    @(negedge clk_i);
    `CHK(halted, 1'b0)
    $display("halt test done");
    end_of_test();
  end
endmodule
